// ===== rtl/input_sync.v
// two-stage synchroniser for a group of asynchronous pins
// assumes pins are level signals slower than the clock
`timescale 1ns/100ps
`default_nettype none

module input_sync #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   // first stage feeds only the second stage
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule

`default_nettype wire

// ===== rtl/pulse_decoder.v
// command pulse pair decoder: sign+pulse, cw/ccw or quadrature
// assumes both lines are already synchronised to clk_i
`timescale 1ns/100ps
`default_nettype none
`include "sifd_regs.vh"

module pulse_decoder (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire [1:0] fmt_i,
   input  wire       line_a_i,
   input  wire       line_b_i,
   output reg        step_o,
   output reg        dir_o
);

   reg       a_ff;
   reg       b_ff;
   reg       nxt_step;
   reg       nxt_dir;

   always @* begin
      nxt_step = 1'b0;
      nxt_dir  = dir_o;
      case (fmt_i)
         `SIFD_FMT_SIGN_PULSE: begin
            nxt_step = line_a_i & ~a_ff;
            nxt_dir  = line_b_i;
         end
         `SIFD_FMT_CW_CCW: begin
            // both edges in one cycle cancel out
            if ((line_a_i & ~a_ff) ^ (line_b_i & ~b_ff)) begin
               nxt_step = 1'b1;
               nxt_dir  = line_a_i & ~a_ff;
            end
         end
         `SIFD_FMT_QUAD: begin
            // x4 decode; a double change is illegal and dropped
            if ((line_a_i ^ a_ff) ^ (line_b_i ^ b_ff)) begin
               nxt_step = 1'b1;
               nxt_dir  = a_ff ^ line_b_i;
            end
         end
         default: begin
            nxt_step = 1'b0;
         end
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         a_ff   <= 1'b0;
         b_ff   <= 1'b0;
         step_o <= 1'b0;
         dir_o  <= 1'b0;
      end else begin
         a_ff   <= line_a_i;
         b_ff   <= line_b_i;
         step_o <= nxt_step;
         dir_o  <= nxt_dir;
      end
   end

endmodule

`default_nettype wire

// ===== rtl/servo_input_function_decoder.v
// servo drive sequence-input function decoder with command pulse counting
// assumes a classic wishbone master on clk_i and asynchronous pins from outside
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "sifd_regs.vh"

module servo_input_function_decoder (
   input  wire        clk_i,
   input  wire        rst_i,
   // ******************************
   // wishbone slave
   // ******************************
   input  wire [7:0]  adr_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   input  wire        we_i,
   input  wire [3:0]  sel_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   output reg         ack_o,
   // ******************************
   // pins
   // ******************************
   input  wire [8:0]  seq_in_i,
   input  wire        command_pulse_i,
   input  wire        command_sign_i,
   input  wire        deviation_clear_i,
   input  wire        abs_data_request_i,
   // ******************************
   // decoded functions
   // ******************************
   output reg         servo_enable_o,
   output reg         forward_travel_limit_o,
   output reg         reverse_travel_limit_o,
   output reg         alarm_reset_input_o,
   output reg         proportional_only_select_o,
   output reg         torque_limit_select_o,
   output reg         preset_speed_direction_o,
   output reg  [1:0]  preset_speed_segment_o,
   output reg         mode_select_o,
   output reg         zero_position_hold_o,
   output reg         pulse_inhibit_o,
   output reg         gain_select_o,
   output reg         pulse_rate_select_o,
   output reg         command_step_o,
   output reg         command_dir_o,
   output reg  [31:0] position_deviation_o,
   output reg         abs_data_start_o
);

   // ******************************
   // helpers
   // ******************************
   localparam CFG_BITS = `SIFD_NUM_IN * `SIFD_CFG_W;

   // any input configured to code and currently asserted
   function func_hit;
      input [CFG_BITS-1:0]     cfg;
      input [`SIFD_NUM_IN-1:0] pins;
      input [7:0]              code;
      integer                  k;
      reg                      level;
      begin
         func_hit = 1'b0;
         for (k = 0; k < `SIFD_NUM_IN; k = k + 1) begin
            // limits are fail-safe: an open wire means stop
            level = pins[k] ^ cfg[k*`SIFD_CFG_W+`SIFD_INV_BIT]
                    ^ (code == `SIFD_F_FWD_LIMIT || code == `SIFD_F_REV_LIMIT);
            if (cfg[k*`SIFD_CFG_W +: 8] == code && level) begin
               func_hit = 1'b1;
            end
         end
      end
   endfunction

   function [31:0] zext9;
      input [8:0] v;
      begin
         zext9 = {23'h000000, v};
      end
   endfunction

   // ******************************
   // pin synchronisers
   // ******************************
   wire [12:0] pins_sync;

   input_sync #(
      .W (13)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({abs_data_request_i, deviation_clear_i, command_sign_i, command_pulse_i, seq_in_i}),
      .sync_o  (pins_sync)
   );

   wire [8:0] seq_s      = pins_sync[8:0];
   wire       clr_s      = pins_sync[11];
   wire       abs_req_s  = pins_sync[12];

   // ******************************
   // registers
   // ******************************
   reg [CFG_BITS-1:0]     cfg_ff;
   reg [`SIFD_CTRL_W-1:0] ctrl_ff;
   reg                    abs_req_ff;

   wire [1:0] fmt      = ctrl_ff[`SIFD_CTRL_FMT_LSB +: 2];
   wire       pos_mode = ctrl_ff[`SIFD_CTRL_POS_BIT];
   wire       spd_mode = ctrl_ff[`SIFD_CTRL_SPD_BIT];
   wire       ispd     = ctrl_ff[`SIFD_CTRL_ISPD_BIT];
   wire       mixed    = ctrl_ff[`SIFD_CTRL_MIX_BIT];
   wire       man_gain = ctrl_ff[`SIFD_CTRL_GAIN_BIT];

   wire       req     = cyc_i & stb_i & ~ack_o;
   wire       cfg_sel = (adr_i[1:0] == 2'h0) && (adr_i <= `SIFD_ADR_FUNC_LAST);
   wire [3:0] cfg_idx = adr_i[5:2];

   // ******************************
   // pulse decoding
   // ******************************
   wire dec_step;
   wire dec_dir;

   pulse_decoder u_pulse (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .fmt_i    (fmt),
      .line_a_i (pins_sync[9]),
      .line_b_i (pins_sync[10]),
      .step_o   (dec_step),
      .dir_o    (dec_dir)
   );

   // ******************************
   // function decode
   // ******************************
   reg nxt_servo_enable;
   reg nxt_fwd_limit;
   reg nxt_rev_limit;
   reg nxt_alarm_reset;
   reg nxt_p_only;
   reg nxt_tlim_sel;
   reg nxt_spd_dir;
   reg nxt_preset_speed_select_a;
   reg nxt_preset_speed_select_b;
   reg nxt_mode_sel;
   reg nxt_zero_hold;
   reg nxt_inhibit;
   reg nxt_gain_sel;
   reg nxt_rate_sel;

   // mode gates keep a function quiet outside the modes that use it
   always @* begin
      nxt_servo_enable = func_hit(cfg_ff, seq_s, `SIFD_F_SERVO_ON);
      nxt_fwd_limit    = func_hit(cfg_ff, seq_s, `SIFD_F_FWD_LIMIT);
      nxt_rev_limit    = func_hit(cfg_ff, seq_s, `SIFD_F_REV_LIMIT);
      nxt_alarm_reset  = func_hit(cfg_ff, seq_s, `SIFD_F_ALARM_RST);
      nxt_p_only       = func_hit(cfg_ff, seq_s, `SIFD_F_P_ONLY);
      nxt_tlim_sel     = func_hit(cfg_ff, seq_s, `SIFD_F_TLIM_SEL);
      nxt_spd_dir      = ispd & func_hit(cfg_ff, seq_s, `SIFD_F_SPD_DIR);
      nxt_preset_speed_select_a        = ispd & func_hit(cfg_ff, seq_s, `SIFD_F_PRESET_SPEED_SELECT_A);
      nxt_preset_speed_select_b        = ispd & func_hit(cfg_ff, seq_s, `SIFD_F_PRESET_SPEED_SELECT_B);
      nxt_mode_sel     = mixed & func_hit(cfg_ff, seq_s, `SIFD_F_MODE_SEL);
      nxt_zero_hold    = spd_mode & func_hit(cfg_ff, seq_s, `SIFD_F_ZERO_HOLD);
      nxt_inhibit      = pos_mode & func_hit(cfg_ff, seq_s, `SIFD_F_INHIBIT);
      nxt_gain_sel     = man_gain & func_hit(cfg_ff, seq_s, `SIFD_F_GAIN_SEL);
      nxt_rate_sel     = pos_mode & func_hit(cfg_ff, seq_s, `SIFD_F_RATE_SEL);
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         servo_enable_o             <= 1'b0;
         forward_travel_limit_o     <= 1'b0;
         reverse_travel_limit_o     <= 1'b0;
         alarm_reset_input_o        <= 1'b0;
         proportional_only_select_o <= 1'b0;
         torque_limit_select_o      <= 1'b0;
         preset_speed_direction_o   <= 1'b0;
         preset_speed_segment_o     <= 2'h0;
         mode_select_o              <= 1'b0;
         zero_position_hold_o       <= 1'b0;
         pulse_inhibit_o            <= 1'b0;
         gain_select_o              <= 1'b0;
         pulse_rate_select_o        <= 1'b0;
      end else begin
         servo_enable_o             <= nxt_servo_enable;
         forward_travel_limit_o     <= nxt_fwd_limit;
         reverse_travel_limit_o     <= nxt_rev_limit;
         alarm_reset_input_o        <= nxt_alarm_reset;
         proportional_only_select_o <= nxt_p_only;
         torque_limit_select_o      <= nxt_tlim_sel;
         preset_speed_direction_o   <= nxt_spd_dir;
         preset_speed_segment_o     <= {nxt_preset_speed_select_b, nxt_preset_speed_select_a};
         mode_select_o              <= nxt_mode_sel;
         zero_position_hold_o       <= nxt_zero_hold;
         pulse_inhibit_o            <= nxt_inhibit;
         gain_select_o              <= nxt_gain_sel;
         pulse_rate_select_o        <= nxt_rate_sel;
      end
   end

   // ******************************
   // position deviation
   // ******************************
   reg [31:0] nxt_deviation;

   // a clear wins over a step that lands in the same cycle
   // wraps silently at 32 bits; the deviation clear pin must reset it in time, as the bus cannot write it
   always @* begin
      nxt_deviation = position_deviation_o;
      if (pos_mode && clr_s) begin
         nxt_deviation = 32'h00000000;
      end else if (command_step_o && command_dir_o) begin
         nxt_deviation = position_deviation_o + 32'h00000001;
      end else if (command_step_o) begin
         nxt_deviation = position_deviation_o - 32'h00000001;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         command_step_o       <= 1'b0;
         command_dir_o        <= 1'b0;
         position_deviation_o <= 32'h00000000;
      end else begin
         // inhibited steps are dropped, not delayed
         command_step_o       <= dec_step & pos_mode & ~nxt_inhibit;
         command_dir_o        <= dec_dir;
         position_deviation_o <= nxt_deviation;
      end
   end

   // ******************************
   // absolute data request
   // ******************************
   // a held request starts the data output only once
   always @(posedge clk_i) begin
      if (rst_i) begin
         abs_req_ff       <= 1'b0;
         abs_data_start_o <= 1'b0;
      end else begin
         abs_req_ff       <= abs_req_s;
         abs_data_start_o <= abs_req_s & ~abs_req_ff;
      end
   end

   // ******************************
   // status and read data
   // ******************************
   wire [13:0] status_bits = {pulse_rate_select_o,
                              gain_select_o,
                              pulse_inhibit_o,
                              zero_position_hold_o,
                              mode_select_o,
                              preset_speed_segment_o,
                              preset_speed_direction_o,
                              torque_limit_select_o,
                              proportional_only_select_o,
                              alarm_reset_input_o,
                              reverse_travel_limit_o,
                              forward_travel_limit_o,
                              servo_enable_o};
   reg  [31:0] nxt_rdata;

   // unmapped words read as zero, so software can probe the map safely
   always @* begin
      nxt_rdata = 32'h00000000;
      if (cfg_sel) begin
         nxt_rdata = zext9(cfg_ff[cfg_idx*`SIFD_CFG_W +: `SIFD_CFG_W]);
      end else begin
         case (adr_i)
            `SIFD_ADR_CTRL: begin
               nxt_rdata = {25'h0000000, ctrl_ff};
            end
            `SIFD_ADR_STATUS: begin
               nxt_rdata = {18'h00000, status_bits};
            end
            `SIFD_ADR_DEVIATION: begin
               nxt_rdata = position_deviation_o;
            end
            `SIFD_ADR_INPUTS: begin
               nxt_rdata = {19'h00000, pins_sync};
            end
            default: begin
               nxt_rdata = 32'h00000000;
            end
         endcase
      end
   end

   // ******************************
   // wishbone slave
   // ******************************
   integer i;

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o   <= 1'b0;
         dat_o   <= 32'h00000000;
         ctrl_ff <= `SIFD_CTRL_RST;
         for (i = 0; i < `SIFD_NUM_IN; i = i + 1) begin
            cfg_ff[i*`SIFD_CFG_W +: `SIFD_CFG_W] <= `SIFD_CFG_RST;
         end
      end else begin
         ack_o <= req;
         dat_o <= 32'h00000000;
         if (req && we_i) begin
            if (cfg_sel) begin
               if (sel_i[0]) begin
                  cfg_ff[cfg_idx*`SIFD_CFG_W +: 8] <= dat_i[7:0];
               end
               if (sel_i[1]) begin
                  cfg_ff[cfg_idx*`SIFD_CFG_W+`SIFD_INV_BIT] <= dat_i[8];
               end
            end else if (adr_i == `SIFD_ADR_CTRL && sel_i[0]) begin
               ctrl_ff <= dat_i[`SIFD_CTRL_W-1:0];
            end
         end else if (req) begin
            dat_o <= nxt_rdata;
         end
      end
   end

endmodule

`default_nettype wire

// ===== rtl/sifd_regs.vh
// register map, field positions and function codes of the input function decoder
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef SIFD_REGS_VH
`define SIFD_REGS_VH

// ******************************
// register byte offsets
// ******************************
`define SIFD_ADR_FUNC0      8'h00
`define SIFD_ADR_FUNC_LAST  8'h20
`define SIFD_ADR_CTRL       8'h24
`define SIFD_ADR_STATUS     8'h28
`define SIFD_ADR_DEVIATION  8'h2c
`define SIFD_ADR_INPUTS     8'h30

// ******************************
// sizes
// ******************************
`define SIFD_NUM_IN         9
`define SIFD_CFG_W          9
`define SIFD_CFG_RST        9'h000

// ******************************
// function number fields
// ******************************
`define SIFD_CODE_MSB       7
`define SIFD_INV_BIT        8

// ******************************
// control register fields
// ******************************
`define SIFD_CTRL_FMT_LSB   0
`define SIFD_CTRL_POS_BIT   2
`define SIFD_CTRL_SPD_BIT   3
`define SIFD_CTRL_ISPD_BIT  4
`define SIFD_CTRL_MIX_BIT   5
`define SIFD_CTRL_GAIN_BIT  6
`define SIFD_CTRL_W         7
`define SIFD_CTRL_RST       7'h00

// ******************************
// pulse formats
// ******************************
`define SIFD_FMT_SIGN_PULSE 2'h0
`define SIFD_FMT_CW_CCW     2'h1
`define SIFD_FMT_QUAD       2'h2

// ******************************
// function codes
// ******************************
`define SIFD_F_SERVO_ON     8'h01
`define SIFD_F_FWD_LIMIT    8'h02
`define SIFD_F_REV_LIMIT    8'h03
`define SIFD_F_ALARM_RST    8'h04
`define SIFD_F_P_ONLY       8'h05
`define SIFD_F_TLIM_SEL     8'h06
`define SIFD_F_SPD_DIR      8'h08
`define SIFD_F_PRESET_SPEED_SELECT_A        8'h09
`define SIFD_F_PRESET_SPEED_SELECT_B        8'h0a
`define SIFD_F_MODE_SEL     8'h0b
`define SIFD_F_ZERO_HOLD    8'h0c
`define SIFD_F_INHIBIT      8'h0d
`define SIFD_F_GAIN_SEL     8'h0e
`define SIFD_F_RATE_SEL     8'h10

`endif

// ===== tb/pulse_host.sv
// host model driving the command pulse pair
// leaves the pulse line low between bursts; the sign line stays at the last direction sent in sign+pulse and low in the other formats
`timescale 1ns/100ps
`default_nettype none
module pulse_host (
   input  wire logic clk_i,
   output var logic  line_a_o,
   output var logic  line_b_o
);
   initial {line_a_o, line_b_o} = 2'h0;
   // three cycles a level, above the two-cycle minimum
   task put(input logic [1:0] v);
      @(posedge clk_i);
      {line_a_o, line_b_o} <= v;
      repeat (2) @(posedge clk_i);
   endtask
   // f 0 sign+pulse, 1 cw/ccw, 2 quadrature; d 1 forward
   task send(input int f, input logic d, input int n);
      logic [7:0] s;
      s = d ? 8'h78 : 8'hb4;
      repeat (n) begin
         if (f == 2) begin
            for (int k = 0; k < 4; k++) put(s[7-2*k -: 2]);
         end else if (f == 1) begin
            put(d ? 2'h2 : 2'h1);
            put(2'h0);
         end else begin
            put({1'b1, d});
            put({1'b0, d});
         end
      end
   endtask
endmodule
`default_nettype wire

// ===== tb/sifd_monitor.sv
// checker for bus handshake, data request delay and deviation steps
// assumes it is bound onto the decoder top ports
`timescale 1ns/100ps
`default_nettype none
module sifd_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        ack_o,
   input wire logic [31:0] dat_o,
   input wire logic        abs_data_request_i,
   input wire logic        abs_data_start_o,
   input wire logic        command_step_o,
   input wire logic [31:0] position_deviation_o
);
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ack_pulse_a:
      assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a:
      assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   take_ack_a:
      assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered next cycle");
   dat_idle_a:
      assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   abs_delay_a:
      assert property ($rose(abs_data_request_i) ##1 abs_data_request_i [*2] |=> abs_data_start_o)
      else $error("data start not four edges after request");
   abs_pulse_a:
      assert property (abs_data_start_o |=> !abs_data_start_o)
      else $error("data start longer than one cycle");
   dev_cause_a:
      assert property (position_deviation_o != $past(position_deviation_o) && position_deviation_o != 32'h0
         |-> $past(command_step_o))
      else $error("deviation moved without a step");
   dev_unit_a:
      assert property (position_deviation_o != $past(position_deviation_o) && position_deviation_o != 32'h0
         |-> position_deviation_o - $past(position_deviation_o) inside {32'h1, 32'hffffffff})
      else $error("deviation moved by more than one");
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the input function decoder
// assumes decoder, header, pulse host and monitor compiled first
`timescale 1ns/100ps
`default_nettype none
`include "sifd_regs.vh"
module tb;
   logic             clk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic [7:0]       adr_i = 8'h0;
   logic [31:0]      dat_i = 32'h0;
   logic             we_i = 1'b0;
   logic [3:0]       sel_i = 4'hf;
   logic             cyc_i = 1'b0;
   logic             stb_i = 1'b0;
   logic [8:0]       seq_in_i = 9'h0;
   logic             deviation_clear_i = 1'b0;
   logic             abs_data_request_i = 1'b0;
   wire logic        command_pulse_i, command_sign_i, ack_o, servo_enable_o, forward_travel_limit_o;
   wire logic        reverse_travel_limit_o, alarm_reset_input_o, proportional_only_select_o;
   wire logic        torque_limit_select_o, preset_speed_direction_o, mode_select_o, zero_position_hold_o;
   wire logic        pulse_inhibit_o, gain_select_o, pulse_rate_select_o, command_step_o, command_dir_o;
   wire logic        abs_data_start_o;
   wire logic [1:0]  preset_speed_segment_o;
   wire logic [31:0] dat_o, position_deviation_o;
   wire logic [13:0] fv = {pulse_rate_select_o, gain_select_o, pulse_inhibit_o, zero_position_hold_o,
      mode_select_o, preset_speed_segment_o, preset_speed_direction_o, torque_limit_select_o,
      proportional_only_select_o, alarm_reset_input_o, reverse_travel_limit_o, forward_travel_limit_o,
      servo_enable_o};
   int               n_mismatch = 0;
   int               checks = 0;
   logic [7:0]       codes [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a,
      8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10};
   always #50 clk_i = ~clk_i;
   servo_input_function_decoder dut (
      .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
      .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .seq_in_i(seq_in_i),
      .command_pulse_i(command_pulse_i), .command_sign_i(command_sign_i),
      .deviation_clear_i(deviation_clear_i), .abs_data_request_i(abs_data_request_i),
      .servo_enable_o(servo_enable_o), .forward_travel_limit_o(forward_travel_limit_o),
      .reverse_travel_limit_o(reverse_travel_limit_o), .alarm_reset_input_o(alarm_reset_input_o),
      .proportional_only_select_o(proportional_only_select_o), .torque_limit_select_o(torque_limit_select_o),
      .preset_speed_direction_o(preset_speed_direction_o), .preset_speed_segment_o(preset_speed_segment_o),
      .mode_select_o(mode_select_o), .zero_position_hold_o(zero_position_hold_o),
      .pulse_inhibit_o(pulse_inhibit_o), .gain_select_o(gain_select_o),
      .pulse_rate_select_o(pulse_rate_select_o), .command_step_o(command_step_o),
      .command_dir_o(command_dir_o), .position_deviation_o(position_deviation_o),
      .abs_data_start_o(abs_data_start_o));
   pulse_host host (.clk_i(clk_i), .line_a_o(command_pulse_i), .line_b_o(command_sign_i));
   // ****************
   // shared tasks
   // ****************
   task complete_run;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
         n_mismatch++;
      end
   endtask
   task bound(input int i);
      if (i >= 20) begin
         n_mismatch++;
         complete_run;
      end
   endtask
   // ack sampled at the edge itself, before the slave updates it
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack_o !== 1'b1 && i < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      bound(i);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(nm, q, e);
   endtask
   function logic [13:0] expf(int i, int v, int p, int m);
      logic act;
      act = p[0] ^ v[0] ^ (i == 1 || i == 2);
      return (act && (m != 0 || i < 6)) ? 14'h1 << i : 14'h0;
   endfunction
   task pin(input logic p, input logic [13:0] eo, input logic [13:0] en);
      @(posedge clk_i);
      seq_in_i[0] <= p;
      repeat (2) @(posedge clk_i);
      #1 chk("sync hold", fv, eo);
      @(posedge clk_i);
      #1 chk("function", fv, en);
   endtask
   task clear;
      @(posedge clk_i);
      deviation_clear_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      deviation_clear_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("cleared", position_deviation_o, 32'h0);
   endtask
   // ****************
   // scenarios
   // ****************
   task t_reset;
      @(posedge clk_i);
      #1 chk("reset functions", fv, 32'h0);
      chk("reset deviation", position_deviation_o, 32'h0);
      rdc("func0 reset", `SIFD_ADR_FUNC0, 32'h0);
      rdc("func8 reset", `SIFD_ADR_FUNC_LAST, 32'h0);
      rdc("ctrl reset", `SIFD_ADR_CTRL, 32'h0);
   endtask
   task t_bus;
      wr(8'h3c, 32'hffffffff);
      rdc("unmapped", 8'h3c, 32'h0);
      wr(`SIFD_ADR_FUNC_LAST, 32'h1ff);
      rdc("func8", `SIFD_ADR_FUNC_LAST, 32'h1ff);
      wr(`SIFD_ADR_FUNC_LAST, 32'h0);
   endtask
   task t_funcs;
      logic [13:0] e0;
      logic [13:0] e1;
      for (int m = 0; m < 2; m++) begin
         wr(`SIFD_ADR_CTRL, m ? 32'h7c : 32'h0);
         for (int i = 0; i < 14; i++) begin
            for (int v = 0; v < 2; v++) begin
               wr(`SIFD_ADR_FUNC0, {23'h0, v[0], codes[i]});
               e0 = expf(i, v, 0, m);
               e1 = expf(i, v, 1, m);
               pin(1'b1, e0, e1);
               pin(1'b0, e1, e0);
            end
         end
      end
      wr(`SIFD_ADR_FUNC0, 32'h0);
   endtask
   task t_pulse;
      for (int f = 0; f < 3; f++) begin
         wr(`SIFD_ADR_CTRL, 32'h4 | f);
         clear;
         host.send(f, 1'b1, 5);
         repeat (6) @(posedge clk_i);
         chk("forward count", position_deviation_o, f == 2 ? 32'h14 : 32'h5);
         chk("forward dir", command_dir_o, 32'h1);
         host.send(f, 1'b0, 3);
         repeat (6) @(posedge clk_i);
         chk("reverse count", position_deviation_o, f == 2 ? 32'h8 : 32'h2);
         chk("reverse dir", command_dir_o, 32'h0);
      end
      rdc("deviation reg", `SIFD_ADR_DEVIATION, 32'h8);
      wr(`SIFD_ADR_CTRL, 32'h7);
      host.send(0, 1'b1, 2);
      repeat (6) @(posedge clk_i);
      chk("no format", position_deviation_o, 32'h8);
   endtask
   task t_inhibit;
      wr(`SIFD_ADR_CTRL, 32'h4);
      wr(`SIFD_ADR_FUNC0, 32'h0d);
      pin(1'b1, 14'h0, 14'h800);
      rdc("status", `SIFD_ADR_STATUS, 32'h800);
      rdc("inputs", `SIFD_ADR_INPUTS, 32'h401);
      clear;
      host.send(0, 1'b1, 4);
      repeat (6) @(posedge clk_i);
      chk("inhibited", position_deviation_o, 32'h0);
      pin(1'b0, 14'h800, 14'h0);
      host.send(0, 1'b1, 4);
      repeat (6) @(posedge clk_i);
      chk("released", position_deviation_o, 32'h4);
   endtask
   task t_abs;
      int i;
      @(posedge clk_i);
      abs_data_request_i <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_i);
         #1 i++;
      end while (abs_data_start_o !== 1'b1 && i < 20);
      bound(i);
      chk("start delay", i, 32'h3);
      @(posedge clk_i);
      abs_data_request_i <= 1'b0;
      #1 chk("start pulse", abs_data_start_o, 32'h0);
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_bus;
      t_funcs;
      t_pulse;
      t_inhibit;
      t_abs;
      complete_run;
   end
endmodule
bind servo_input_function_decoder sifd_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .abs_data_request_i(abs_data_request_i),
   .abs_data_start_o(abs_data_start_o), .command_step_o(command_step_o),
   .position_deviation_o(position_deviation_o));
`default_nettype wire
